// ===== hdl/abt_term.sv
// Terminal end: command framing, response assembly, toolkit handling
`timescale 1ns/1ns
module abt_term (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  abt_link_if.term              link,
  input  wire logic             cmdStart,
  input  wire abt_pkg::abt_kind_e cmdKind,
  input  wire logic [7:0]       cmdLc,
  input  wire logic [7:0]       cmdData,
  input  wire logic             cmdValid,
  input  wire logic             cmdLast,
  output logic                  cmdReady,
  output logic                  busy,
  input  wire logic             autoFetch,
  output logic [7:0]            rspData,
  output logic                  rspValid,
  output logic                  rspLast,
  output logic                  rspFetched,
  output logic [15:0]           rspSw,
  output logic                  proactivePending,
  output logic                  envAck,
  output logic                  envNak
);

  typedef enum logic [2:0] {
    TS_IDLE,
    TS_HDR,
    TS_BODY,
    TS_LE,
    TS_WAIT
  } abt_tstate_e;

  abt_tstate_e        state_reg;
  abt_tstate_e        state_next;
  abt_pkg::abt_kind_e kind_reg;
  logic [7:0]         lc_reg;
  logic [2:0]         hdrIdx_reg;
  logic               isFetch_reg;
  logic [7:0]         ins_reg;
  logic [1:0]         bodyIdx_reg;
  logic [7:0]         blkCnt_reg;
  logic [15:0]        swShift_reg;
  logic [7:0]         pendLen_reg;
  logic               txFire;
  logic               txFinal;
  logic [7:0]         txByte;
  logic               rspEnd;
  logic [15:0]        endSw;
  logic               startFetch;

  // ==========================================================================
  // Command sequencing
  // A pending fetch wins over a new user command when auto fetch is on
  assign startFetch = proactivePending && autoFetch;

  always_comb begin
    state_next = state_reg;
    txFire     = 1'b0;
    txFinal    = 1'b0;
    txByte     = 8'h00;
    case (state_reg)
      TS_IDLE: begin
        if (startFetch)
          state_next = TS_HDR;
        else if (cmdStart && cmdKind == abt_pkg::ABT_KIND_RAW)
          state_next = TS_BODY;
        else if (cmdStart)
          state_next = TS_HDR;
      end
      TS_HDR: begin
        txFire = 1'b1;
        case (hdrIdx_reg)
          3'd0:    txByte = abt_pkg::TOOLKIT_CLA;
          3'd1:    txByte = ins_reg;
          3'd4:    txByte = isFetch_reg ? pendLen_reg : lc_reg;
          default: txByte = abt_pkg::P1P2_DEFAULT;
        endcase
        if (hdrIdx_reg == 3'd4) begin
          txFinal    = isFetch_reg;
          state_next = isFetch_reg ? TS_WAIT : TS_BODY;
        end
      end
      TS_BODY: begin
        txFire = cmdValid && cmdReady;
        txByte = cmdData;
        if (txFire && cmdLast) begin
          txFinal    = kind_reg != abt_pkg::ABT_KIND_ENVELOPE;
          state_next = (kind_reg == abt_pkg::ABT_KIND_ENVELOPE) ?
                       TS_LE : TS_WAIT;
        end
      end
      TS_LE: begin
        txFire     = 1'b1;
        txFinal    = 1'b1;
        txByte     = abt_pkg::LE_ENVELOPE;
        state_next = TS_WAIT;
      end
      TS_WAIT: begin
        if (rspEnd)
          state_next = TS_IDLE;
      end
      default: state_next = TS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= TS_IDLE;
      cmdReady  <= 1'b0;
      busy      <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmdReady  <= state_next == TS_BODY;
      busy      <= state_next != TS_IDLE;
    end
  end

  // ==========================================================================
  // Command parameters and header index
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      kind_reg    <= abt_pkg::ABT_KIND_RAW;
      lc_reg      <= 8'h00;
      isFetch_reg <= 1'b0;
      ins_reg     <= 8'h00;
      hdrIdx_reg  <= 3'd0;
      bodyIdx_reg <= 2'd0;
    end else begin
      if (state_reg == TS_IDLE) begin
        hdrIdx_reg  <= 3'd0;
        bodyIdx_reg <= 2'd0;
        if (startFetch) begin
          isFetch_reg <= 1'b1;
          kind_reg    <= abt_pkg::ABT_KIND_RAW;
          ins_reg     <= abt_pkg::INS_FETCH;
        end else if (cmdStart) begin
          isFetch_reg <= 1'b0;
          kind_reg    <= cmdKind;
          lc_reg      <= cmdLc;
          if (cmdKind == abt_pkg::ABT_KIND_ENVELOPE)
            ins_reg <= abt_pkg::INS_ENVELOPE;
          else if (cmdKind == abt_pkg::ABT_KIND_TERM_RSP)
            ins_reg <= abt_pkg::INS_TERM_RSP;
        end
      end else if (state_reg == TS_HDR) begin
        hdrIdx_reg <= hdrIdx_reg + 3'd1;
      end else if (state_reg == TS_BODY && txFire &&
                   kind_reg == abt_pkg::ABT_KIND_RAW) begin
        // Raw commands carry their own instruction in the second byte
        if (bodyIdx_reg == 2'd1)
          ins_reg <= cmdData;
        if (bodyIdx_reg != 2'd2)
          bodyIdx_reg <= bodyIdx_reg + 2'd1;
      end
    end
  end

  // ==========================================================================
  // Block framing of the outgoing command
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link.t2cValid <= 1'b0;
      link.t2cData  <= 8'h00;
      link.t2cLast  <= 1'b0;
      link.t2cMore  <= 1'b0;
      blkCnt_reg    <= 8'h00;
    end else begin
      link.t2cValid <= txFire;
      link.t2cData  <= txByte;
      link.t2cLast  <= txFire &&
                       (txFinal || abt_pkg::blockFull(blkCnt_reg));
      link.t2cMore  <= txFire && !txFinal &&
                       abt_pkg::blockFull(blkCnt_reg);
      if (txFire)
        blkCnt_reg <= (txFinal || abt_pkg::blockFull(blkCnt_reg)) ?
                      8'h00 : blkCnt_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Response assembly
  assign rspEnd = link.c2tValid && link.c2tLast && !link.c2tMore;
  assign endSw  = {swShift_reg[7:0], link.c2tData};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rspValid    <= 1'b0;
      rspData     <= 8'h00;
      rspLast     <= 1'b0;
      rspFetched  <= 1'b0;
      swShift_reg <= 16'h0000;
    end else begin
      rspValid   <= link.c2tValid;
      rspData    <= link.c2tData;
      rspLast    <= rspEnd;
      rspFetched <= link.c2tValid && isFetch_reg;
      if (link.c2tValid)
        swShift_reg <= endSw;
    end
  end

  // ==========================================================================
  // Toolkit status handling
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rspSw            <= 16'h0000;
      proactivePending <= 1'b0;
      pendLen_reg      <= 8'h00;
      envAck           <= 1'b0;
      envNak           <= 1'b0;
    end else begin
      envAck <= rspEnd && ins_reg == abt_pkg::INS_ENVELOPE &&
                endSw == abt_pkg::SW_SUCCESS;
      envNak <= rspEnd && ins_reg == abt_pkg::INS_ENVELOPE &&
                (endSw[15:8] == abt_pkg::SW1_WARN_A ||
                 endSw[15:8] == abt_pkg::SW1_WARN_B);
      if (rspEnd) begin
        rspSw            <= endSw;
        proactivePending <= endSw[15:8] == abt_pkg::SW1_PROACTIVE;
        pendLen_reg      <= endSw[7:0];
      end else if (state_reg == TS_IDLE && startFetch)
        proactivePending <= 1'b0;
    end
  end

endmodule // abt_term

// ===== hdl/abt_pkg.sv
// Shared constants, types and helpers for the APDU block transport ends
//
// Functional notes
// - Command bytes enter the block field unaltered
// - Data only with 61/62/63/9X status
// - Other status words go without data
// - Terminal passes response bytes unmodified upward
// - Chained response blocks concatenate in order
// - Long commands split into chained blocks
// - Case 4 response chained, concatenated by terminal
// - Four exchange cases all supported
// - Pending proactive command turns 9000 into 91XX
// - Fetch uses INS 12, Le from SW2
// - Terminal response uses INS 14 with data
// - Envelope is case 4, INS C2, Le 00
// - Envelope 9000 data goes to ack channel
// - Envelope 62XX/63XX data goes to error channel
// - Busy toolkit layer answers envelope with 9300
package abt_pkg;

  // ==========================================================================
  // Block sizing
  localparam logic [7:0]  IFS_LAST_IDX    = 8'h1F;

  // ==========================================================================
  // Instruction and header bytes
  localparam logic [7:0]  INS_FETCH       = 8'h12;
  localparam logic [7:0]  INS_TERM_RSP    = 8'h14;
  localparam logic [7:0]  INS_ENVELOPE    = 8'hC2;
  localparam logic [7:0]  LE_ENVELOPE     = 8'h00;
  localparam logic [7:0]  P1P2_DEFAULT    = 8'h00;
  localparam logic [7:0]  TOOLKIT_CLA     = 8'h80;

  // ==========================================================================
  // Status words
  localparam logic [7:0]  SW1_NORMAL      = 8'h61;
  localparam logic [7:0]  SW1_WARN_A      = 8'h62;
  localparam logic [7:0]  SW1_WARN_B      = 8'h63;
  localparam logic [3:0]  SW1_APP_NIBBLE  = 4'h9;
  localparam logic [7:0]  SW1_PROACTIVE   = 8'h91;
  localparam logic [15:0] SW_SUCCESS      = 16'h9000;
  localparam logic [15:0] SW_TOOLKIT_BUSY = 16'h9300;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ABT_KIND_RAW,
    ABT_KIND_ENVELOPE,
    ABT_KIND_TERM_RSP
  } abt_kind_e;

  // ==========================================================================
  // Helpers
  // Status words that may carry response data
  function automatic logic swCarriesData(input logic [15:0] sw);
    return (sw[15:8] == SW1_NORMAL) || (sw[15:8] == SW1_WARN_A) ||
           (sw[15:8] == SW1_WARN_B) || (sw[15:12] == SW1_APP_NIBBLE);
  endfunction

  // Byte counter at the last slot of a block field
  function automatic logic blockFull(input logic [7:0] cnt);
    return cnt == IFS_LAST_IDX;
  endfunction

endpackage

// ===== hdl/abt_link_if.sv
// Byte-level I-block link between terminal and card
`timescale 1ns/1ns
interface abt_link_if;
  logic [7:0] t2cData;
  logic       t2cValid;
  logic       t2cLast;
  logic       t2cMore;
  logic [7:0] c2tData;
  logic       c2tValid;
  logic       c2tLast;
  logic       c2tMore;

  modport card (
    input  t2cData, t2cValid, t2cLast, t2cMore,
    output c2tData, c2tValid, c2tLast, c2tMore
  );

  modport term (
    output t2cData, t2cValid, t2cLast, t2cMore,
    input  c2tData, c2tValid, c2tLast, c2tMore
  );
endinterface

// ===== hdl/abt_card.sv
// Card end: command reassembly and status-driven response framing
`timescale 1ns/1ns
module abt_card (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  abt_link_if.card         link,
  output logic [7:0]       cmdData,
  output logic             cmdValid,
  output logic             cmdLast,
  output logic             cmdRefused,
  input  wire logic        rspStart,
  input  wire logic [15:0] rspSw,
  input  wire logic [7:0]  rspLen,
  input  wire logic [7:0]  rspData,
  input  wire logic        rspValid,
  output logic             rspReady,
  output logic             rspDone,
  input  wire logic        proactivePending,
  input  wire logic [7:0]  proactiveLen,
  input  wire logic        toolkitBusy
);

  typedef enum logic [1:0] {CS_IDLE, CS_DATA, CS_SW1, CS_SW2} abt_cstate_e;

  abt_cstate_e state_reg;
  abt_cstate_e state_next;
  logic [1:0]  rxIdx_reg;
  logic [7:0]  rxIns_reg;
  logic        autoBusy_reg;
  logic [15:0] sw_reg;
  logic [7:0]  remain_reg;
  logic [7:0]  blkCnt_reg;
  logic        txFire;
  logic        txFinal;
  logic [7:0]  txByte;
  logic [7:0]  insNow;
  logic        cmdEnd;
  logic [15:0] swSel;

  // ==========================================================================
  // Command reassembly
  assign cmdEnd = link.t2cValid && link.t2cLast && !link.t2cMore;
  assign insNow = (rxIdx_reg == 2'd1) ? link.t2cData : rxIns_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmdValid <= 1'b0;
      cmdData  <= 8'h00;
      cmdLast  <= 1'b0;
    end else begin
      cmdValid <= link.t2cValid;
      cmdData  <= link.t2cData;
      cmdLast  <= cmdEnd;
    end
  end

  // Byte index within the command, to find the instruction byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxIdx_reg <= 2'd0;
      rxIns_reg <= 8'h00;
    end else if (link.t2cValid) begin
      if (cmdEnd)
        rxIdx_reg <= 2'd0;
      else if (rxIdx_reg != 2'd2)
        rxIdx_reg <= rxIdx_reg + 2'd1;
      if (rxIdx_reg == 2'd1)
        rxIns_reg <= link.t2cData;
    end
  end

  // Envelope refused while the toolkit layer is busy
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmdRefused   <= 1'b0;
      autoBusy_reg <= 1'b0;
    end else begin
      cmdRefused <= cmdEnd && (insNow == abt_pkg::INS_ENVELOPE) &&
                    toolkitBusy;
      if (cmdEnd && (insNow == abt_pkg::INS_ENVELOPE) && toolkitBusy)
        autoBusy_reg <= 1'b1;
      else if (state_reg == CS_IDLE)
        autoBusy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Response sequencing
  assign swSel = (rspSw == abt_pkg::SW_SUCCESS && proactivePending) ?
                 {abt_pkg::SW1_PROACTIVE, proactiveLen} : rspSw;

  always_comb begin
    state_next = state_reg;
    txFire     = 1'b0;
    txFinal    = 1'b0;
    txByte     = 8'h00;
    case (state_reg)
      CS_IDLE: begin
        if (autoBusy_reg)
          state_next = CS_SW1;
        else if (rspStart && abt_pkg::swCarriesData(swSel) &&
                 rspLen != 8'h00)
          state_next = CS_DATA;
        else if (rspStart)
          state_next = CS_SW1;
      end
      CS_DATA: begin
        txFire = rspValid && rspReady;
        txByte = rspData;
        if (txFire && remain_reg == 8'h01)
          state_next = CS_SW1;
      end
      CS_SW1: begin
        txFire     = 1'b1;
        txByte     = sw_reg[15:8];
        state_next = CS_SW2;
      end
      CS_SW2: begin
        txFire     = 1'b1;
        txFinal    = 1'b1;
        txByte     = sw_reg[7:0];
        state_next = CS_IDLE;
      end
      default: state_next = CS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg  <= CS_IDLE;
      sw_reg     <= 16'h0000;
      remain_reg <= 8'h00;
      rspReady   <= 1'b0;
      rspDone    <= 1'b0;
    end else begin
      state_reg <= state_next;
      rspReady  <= state_next == CS_DATA;
      rspDone   <= state_reg == CS_SW2;
      if (state_reg == CS_IDLE && autoBusy_reg)
        sw_reg <= abt_pkg::SW_TOOLKIT_BUSY;
      else if (state_reg == CS_IDLE && rspStart) begin
        sw_reg     <= swSel;
        remain_reg <= rspLen;
      end else if (txFire && state_reg == CS_DATA)
        remain_reg <= remain_reg - 8'h01;
    end
  end

  // ==========================================================================
  // Block framing of the outgoing response
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link.c2tValid <= 1'b0;
      link.c2tData  <= 8'h00;
      link.c2tLast  <= 1'b0;
      link.c2tMore  <= 1'b0;
      blkCnt_reg    <= 8'h00;
    end else begin
      link.c2tValid <= txFire;
      link.c2tData  <= txByte;
      link.c2tLast  <= txFire &&
                       (txFinal || abt_pkg::blockFull(blkCnt_reg));
      link.c2tMore  <= txFire && !txFinal &&
                       abt_pkg::blockFull(blkCnt_reg);
      if (txFire)
        blkCnt_reg <= (txFinal || abt_pkg::blockFull(blkCnt_reg)) ?
                      8'h00 : blkCnt_reg + 8'h01;
    end
  end

endmodule // abt_card

// ===== tb/abt_link_properties.sv
// Link checker for the terminal-card I-block interface
`timescale 1ns/1ns
module abt_link_properties (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic [7:0] t2cData,
  input wire logic       t2cValid,
  input wire logic       t2cLast,
  input wire logic       t2cMore,
  input wire logic [7:0] c2tData,
  input wire logic       c2tValid,
  input wire logic       c2tLast,
  input wire logic       c2tMore
);
  // =====================
  // Byte positions in block and unit
  logic [7:0] tBlk, tAll, tIns, cBlk, cAll, cPrev;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tBlk <= 8'h00;
      tAll <= 8'h00;
      tIns <= 8'h00;
    end else if (t2cValid) begin
      tBlk <= t2cLast ? 8'h00 : tBlk + 8'h01;
      tAll <= (t2cLast && !t2cMore) ? 8'h00 : tAll + 8'h01;
      if (tAll == 8'h01)
        tIns <= t2cData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cBlk <= 8'h00;
      cAll <= 8'h00;
      cPrev <= 8'h00;
    end else if (c2tValid) begin
      cBlk <= c2tLast ? 8'h00 : cBlk + 8'h01;
      cAll <= (c2tLast && !c2tMore) ? 8'h00 : cAll + 8'h01;
      cPrev <= c2tData;
    end
  end

  // =====================
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_t_chain; t2cMore |-> t2cLast && t2cValid; endproperty
  a_t_chain: assert property (p_t_chain)
    else $error("t2c chain flag without closing byte");
  property p_c_chain; c2tMore |-> c2tLast && c2tValid; endproperty
  a_c_chain: assert property (p_c_chain)
    else $error("c2t chain flag without closing byte");
  property p_t_full; t2cValid && t2cMore |-> tBlk == 8'h1F; endproperty
  a_t_full: assert property (p_t_full)
    else $error("chained command block not 32 bytes");
  property p_c_full; c2tValid && !c2tLast |-> cBlk != 8'h1F; endproperty
  a_c_full: assert property (p_c_full)
    else $error("response block longer than 32 bytes");
  property p_sw_tail; c2tValid && c2tLast && !c2tMore |-> cAll >= 8'h01;
  endproperty
  a_sw_tail: assert property (p_sw_tail)
    else $error("response shorter than two status bytes");
  property p_data_sw;
    c2tValid && c2tLast && !c2tMore && cAll > 8'h01 |->
      cPrev inside {8'h61, 8'h62, 8'h63} || cPrev[7:4] == 4'h9;
  endproperty
  a_data_sw: assert property (p_data_sw)
    else $error("response data with a status that forbids it");
  property p_env_le;
    t2cValid && t2cLast && !t2cMore && tIns == 8'hC2 && tAll > 8'h04 |->
      t2cData == 8'h00;
  endproperty
  a_env_le: assert property (p_env_le)
    else $error("envelope not closed by a zero expected length");
  property p_c_end; c2tValid && c2tLast && !c2tMore |=> !c2tValid;
  endproperty
  a_c_end: assert property (p_c_end)
    else $error("byte sent after the closing status byte");
  property p_duplex; c2tValid |-> !t2cValid; endproperty
  a_duplex: assert property (p_duplex)
    else $error("both link directions active together");
endmodule // abt_link_properties

// ===== tb/testbench.sv
// Self-checking bench: terminal and card ends joined over the link
`timescale 1ns/1ns
module testbench;
  typedef logic [7:0] abt_bq_t [$];
  logic               core_clk = 1'b0;
  logic               reset_n, cCmdValid, cCmdLast, cRefused, cRspStart;
  logic               cRspValid, cRspReady, cRspDone, cPend, cTkBusy;
  logic               tStart, tValid, tLast, tReady, tBusy, tAuto;
  logic               tRspValid, tRspLast, tFetched, tPend, tAck, tNak;
  logic               gotCmd, gotRef, fetched, ack, nak, pend;
  logic [7:0]         cCmdData, cRspLen, cRspData, cPlen, tLc, tData;
  logic [7:0]         tRspData;
  logic [15:0]        cRspSw, tSw;
  abt_pkg::abt_kind_e tKind;
  abt_bq_t            cq, rq, e;
  int                 n_mismatch = 0;
  int                 checks = 0;
  int                 cyc = 0;
  int                 nLast = 0;
  logic [15:0]        swT [5] = '{16'h9000, 16'h6205, 16'h9F10, 16'h6A82,
                                  16'h6F00};

  always #20 core_clk = ~core_clk;

  abt_link_if abt_link_if_inst ();
  abt_card abt_card_inst (
    .core_clk(core_clk), .reset_n(reset_n), .link(abt_link_if_inst),
    .cmdData(cCmdData), .cmdValid(cCmdValid), .cmdLast(cCmdLast),
    .cmdRefused(cRefused), .rspStart(cRspStart), .rspSw(cRspSw),
    .rspLen(cRspLen), .rspData(cRspData), .rspValid(cRspValid),
    .rspReady(cRspReady), .rspDone(cRspDone), .proactivePending(cPend),
    .proactiveLen(cPlen), .toolkitBusy(cTkBusy));
  abt_term abt_term_inst (
    .core_clk(core_clk), .reset_n(reset_n), .link(abt_link_if_inst),
    .cmdStart(tStart), .cmdKind(tKind), .cmdLc(tLc), .cmdData(tData),
    .cmdValid(tValid), .cmdLast(tLast), .cmdReady(tReady), .busy(tBusy),
    .autoFetch(tAuto), .rspData(tRspData), .rspValid(tRspValid),
    .rspLast(tRspLast), .rspFetched(tFetched), .rspSw(tSw),
    .proactivePending(tPend), .envAck(tAck), .envNak(tNak));
  abt_link_properties abt_link_properties_inst (
    .core_clk(core_clk), .reset_n(reset_n),
    .t2cData(abt_link_if_inst.t2cData), .t2cValid(abt_link_if_inst.t2cValid),
    .t2cLast(abt_link_if_inst.t2cLast), .t2cMore(abt_link_if_inst.t2cMore),
    .c2tData(abt_link_if_inst.c2tData), .c2tValid(abt_link_if_inst.c2tValid),
    .c2tLast(abt_link_if_inst.c2tLast), .c2tMore(abt_link_if_inst.c2tMore));

  // =====================
  // Monitors and timeout
  always @(posedge core_clk) begin
    if (cCmdValid) cq.push_back(cCmdData);
    if (cCmdLast) gotCmd = 1'b1;
    if (cRefused) gotRef = 1'b1;
    if (tRspValid) rq.push_back(tRspData);
    if (tRspLast) nLast++;
    if (tFetched) fetched = 1'b1;
    if (tAck) ack = 1'b1;
    if (tNak) nak = 1'b1;
    if (tPend) pend = 1'b1;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // =====================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] ex, got);
    checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chkq(input string nm, input abt_bq_t ex, got);
    chk(nm, 16'(ex.size()), 16'(got.size()));
    for (int i = 0; i < ex.size() && i < got.size(); i++)
      chk(nm, {8'h00, ex[i]}, {8'h00, got[i]});
  endtask

  function automatic abt_bq_t seq(input logic [7:0] b, input int n);
    abt_bq_t q;
    for (int i = 0; i < n; i++) q.push_back(8'(b + i));
    return q;
  endfunction

  task automatic term_cmd(input abt_pkg::abt_kind_e kd, input logic [7:0] lc,
                          input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    tStart = 1'b1;
    tKind = kd;
    tLc = lc;
    tValid = 1'b1;
    tData = 8'h30;
    tLast = (n == 1);
    while (k < n && t < 400) begin
      @(posedge core_clk);
      if (tValid && tReady) k++;
      #1;
      tStart = 1'b0;
      tData = 8'(8'h30 + k);
      tLast = (k == n - 1);
      tValid = (k < n);
      t++;
    end
  endtask

  task automatic card_reply(input logic [15:0] sw, input logic [7:0] ln);
    int k;
    int t;
    k = 0;
    t = 0;
    cRspStart = 1'b1;
    cRspSw = sw;
    cRspLen = ln;
    cRspValid = (ln != 8'h00);
    cRspData = 8'hA0;
    while (!cRspDone && t < 400) begin
      @(posedge core_clk);
      if (cRspValid && cRspReady) k++;
      #1;
      cRspStart = 1'b0;
      cRspData = 8'(8'hA0 + k);
      if (k == ln) cRspValid = 1'b0;
      t++;
    end
    cRspValid = 1'b0;
  endtask

  // One command-response exchange; go low waits for an automatic fetch
  task automatic xfer(input logic go, input abt_pkg::abt_kind_e kd,
                      input logic [7:0] lc, input int n,
                      input logic [15:0] sw, input logic [7:0] ln);
    int t;
    cq.delete();
    rq.delete();
    {gotCmd, gotRef, fetched, ack, nak, pend} = 6'h00;
    nLast = 0;
    if (go) term_cmd(kd, lc, n);
    for (t = 0; !gotCmd && t < 400; t++) begin
      @(posedge core_clk);
      #1;
    end
    chk("command seen", 16'h0001, {15'h0, gotCmd});
    if (!gotRef) card_reply(sw, ln);
    for (t = 0; tBusy && t < 400; t++) begin
      @(posedge core_clk);
      #1;
    end
    chk("exchange over", 16'h0000, {15'h0, tBusy});
    // Last byte and end pulses appear in the cycle busy drops; the monitor counts them on the next edge
    @(posedge core_clk);
    #1;
    chk("response end", 16'h0001, 16'(nLast));
    $display("exchange done, status %h", tSw);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================
  // Test sequence
  initial begin
    {reset_n, cRspStart, cRspValid, cPend, cTkBusy} = 5'h00;
    {tStart, tValid, tLast} = 3'h0;
    {cRspSw, cRspLen, cRspData, cPlen, tLc, tData} = 56'h0;
    tKind = abt_pkg::ABT_KIND_RAW;
    tAuto = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    xfer(1'b1, abt_pkg::ABT_KIND_RAW, 8'h00, 4, 16'h9000, 8'h00);
    chkq("case1 command", seq(8'h30, 4), cq);
    chkq("case1 response", {8'h90, 8'h00}, rq);
    xfer(1'b1, abt_pkg::ABT_KIND_RAW, 8'h00, 40, 16'h6100, 8'd40);
    chkq("chained command", seq(8'h30, 40), cq);
    chkq("chained response", {seq(8'hA0, 40), 8'h61, 8'h00}, rq);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, abt_pkg::ABT_KIND_RAW, 8'h00, 5, swT[i], 8'h03);
      e = seq(8'hA0, (swT[i][15:8] inside {8'h61, 8'h62, 8'h63} ||
                      swT[i][15:12] == 4'h9) ? 3 : 0);
      e.push_back(swT[i][15:8]);
      e.push_back(swT[i][7:0]);
      chkq("status data", e, rq);
      chk("status word", swT[i], tSw);
    end
    cPend = 1'b1;
    cPlen = 8'h05;
    tAuto = 1'b0;
    xfer(1'b1, abt_pkg::ABT_KIND_RAW, 8'h00, 4, 16'h9000, 8'h00);
    cPend = 1'b0;
    chkq("pending status", {8'h91, 8'h05}, rq);
    chk("pending flag", 16'h0001, {15'h0, pend});
    repeat (4) @(posedge core_clk);
    #1;
    chk("fetch held", 16'h0001, {14'h0, tBusy, tPend});
    tAuto = 1'b1;
    xfer(1'b0, abt_pkg::ABT_KIND_RAW, 8'h00, 0, 16'h9000, 8'h05);
    chkq("fetch command", {8'h80, 8'h12, 8'h00, 8'h00, 8'h05}, cq);
    chkq("fetch response", {seq(8'hA0, 5), 8'h90, 8'h00}, rq);
    chk("fetch flag", 16'h0001, {15'h0, fetched});
    xfer(1'b1, abt_pkg::ABT_KIND_TERM_RSP, 8'h02, 2, 16'h9000, 8'h00);
    chkq("result command", {8'h80, 8'h14, 8'h00, 8'h00, 8'h02, 8'h30,
                            8'h31}, cq);
    xfer(1'b1, abt_pkg::ABT_KIND_ENVELOPE, 8'h03, 3, 16'h9000, 8'h02);
    chkq("envelope", {8'h80, 8'hC2, 8'h00, 8'h00, 8'h03, 8'h30, 8'h31,
                      8'h32, 8'h00}, cq);
    chk("envelope ack", 16'h0002, {14'h0, ack, nak});
    xfer(1'b1, abt_pkg::ABT_KIND_ENVELOPE, 8'h03, 3, 16'h6301, 8'h01);
    chk("envelope nak", 16'h0001, {14'h0, ack, nak});
    cTkBusy = 1'b1;
    xfer(1'b1, abt_pkg::ABT_KIND_ENVELOPE, 8'h03, 3, 16'h0000, 8'h00);
    cTkBusy = 1'b0;
    chk("busy refusal", 16'h0001, {15'h0, gotRef});
    chkq("busy status", {8'h93, 8'h00}, rq);
    final_report();
  end
endmodule // testbench
